// ---- rcm_cfg.svh ----
// Constants for the reconfiguration management register port
`ifndef RCM_CFG_SVH
`define RCM_CFG_SVH

// ----------------------------------------------------------------------
// Bus widths and feature count
// ----------------------------------------------------------------------
`define RCM_ADDR_W      7
`define RCM_DATA_W      32
`define RCM_NUM_FEAT    7
`define RCM_OFFS_W      3

// ----------------------------------------------------------------------
// Feature windows, byte addresses, first and last byte
// ----------------------------------------------------------------------
`define RCM_ANALOG_LO   7'h08
`define RCM_ANALOG_HI   7'h0C
`define RCM_EYEMON_LO   7'h10
`define RCM_EYEMON_HI   7'h14
`define RCM_DFE_LO      7'h18
`define RCM_DFE_HI      7'h1C
`define RCM_AEQ_LO      7'h28
`define RCM_AEQ_HI      7'h2C
`define RCM_PLLCAL_LO   7'h30
`define RCM_PLLCAL_HI   7'h34
`define RCM_STREAM_LO   7'h38
`define RCM_STREAM_HI   7'h3C
`define RCM_PLLRCF_LO   7'h40
`define RCM_PLLRCF_HI   7'h44

// ----------------------------------------------------------------------
// Reset and unmapped read values
// ----------------------------------------------------------------------
`define RCM_RDATA_RST   32'h0000_0000
`define RCM_UNMAPPED_RD 32'h0000_0000

`endif

// ---- rcm_pkg.sv ----
// Types for the reconfiguration management register port
package rcm_pkg;

    // ------------------------------------------------------------------
    // Feature identifiers, index into the select and read-data vectors
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        RCM_FEAT_ANALOG = 3'b000,
        RCM_FEAT_EYEMON = 3'b001,
        RCM_FEAT_DFE    = 3'b010,
        RCM_FEAT_AEQ    = 3'b011,
        RCM_FEAT_PLLCAL = 3'b100,
        RCM_FEAT_STREAM = 3'b101,
        RCM_FEAT_PLLRCF = 3'b110
    } rcm_feat_e;

    typedef logic [31:0] rcm_data_t;
    typedef logic [6:0]  rcm_addr_t;

endpackage : rcm_pkg

// ---- rcm_window.sv ----
// Address window decoder for one register feature
`timescale 1ns/1ps
`include "rcm_cfg.svh"

module rcm_window
    import rcm_pkg::*;
#(
    parameter logic [6:0] LO = 7'h00,
    parameter logic [6:0] HI = 7'h00
) (
    input  wire logic [6:0] addr,
    output logic            hit,
    output logic [2:0]      offset
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    // Offset port is 3 bits wide, so a window spans at most 8 bytes
    if (HI < LO || (HI - LO) > 7'h07) begin : g_bad_window
        $error("rcm_window: window bounds unusable");
    end

    // Inclusive range compare, offset relative to the window base
    always_comb begin
        logic [6:0] diff;
        diff   = addr - LO;
        hit    = (addr >= LO) && (addr <= HI);
        offset = diff[2:0];
    end

endmodule : rcm_window

// ---- rcm_port.sv ----
// Reconfiguration management register port: decode and routing
//
// Function
// - The port is a memory-mapped slave reaching all controller registers.
// - Management reset is active high and level held; it idles the port.
// - The 7-bit address is a byte address, not a word index.
// - Each feature owns a window; no access reaches another feature.
// - 0x08-0x0C analog, 0x10-0x14 eye monitor, 0x18-0x1C feedback EQ.
// - 0x28-2C AEQ, 0x30-34 PLL cal, 0x38-3C streamer, 0x40-44 PLL reconfig.
// - Busy is high while any operation runs; the master waits for its fall.
`timescale 1ns/1ps
`include "rcm_cfg.svh"

module rcm_port
    import rcm_pkg::*;
#(
    parameter int NUM_FEAT = `RCM_NUM_FEAT,
    parameter int DATA_W   = `RCM_DATA_W
) (
    input  wire logic                     clock,
    input  wire logic                     reset_n,
    input  wire logic                     mgmt_reset,
    // Master side
    input  wire logic [6:0]               mgmt_address,
    input  wire logic [DATA_W-1:0]        mgmt_writedata,
    input  wire logic                     mgmt_write,
    input  wire logic                     mgmt_read,
    output logic      [DATA_W-1:0]        mgmt_readdata,
    output logic                          mgmt_readdatavalid,
    output logic                          reconfig_busy,
    // Feature side
    output logic      [NUM_FEAT-1:0]      feat_sel,
    output logic      [2:0]               feat_offset,
    output logic                          feat_write,
    output logic                          feat_read,
    output logic      [DATA_W-1:0]        feat_writedata,
    input  wire logic [NUM_FEAT*DATA_W-1:0] feat_readdata,
    input  wire logic [NUM_FEAT-1:0]      feat_busy
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (NUM_FEAT != `RCM_NUM_FEAT) begin : g_bad_feat
        $error("rcm_port: window table holds exactly seven features");
    end
    if (DATA_W != `RCM_DATA_W) begin : g_bad_width
        $error("rcm_port: data path is 32 bits");
    end

    // ------------------------------------------------------------------
    // Window table
    // ------------------------------------------------------------------
    // Bases sit on eight-byte steps, so the offset is the low address bits
    localparam logic [6:0] WIN_LO [`RCM_NUM_FEAT] = '{
        `RCM_ANALOG_LO, `RCM_EYEMON_LO, `RCM_DFE_LO, `RCM_AEQ_LO,
        `RCM_PLLCAL_LO, `RCM_STREAM_LO, `RCM_PLLRCF_LO
    };
    localparam logic [6:0] WIN_HI [`RCM_NUM_FEAT] = '{
        `RCM_ANALOG_HI, `RCM_EYEMON_HI, `RCM_DFE_HI, `RCM_AEQ_HI,
        `RCM_PLLCAL_HI, `RCM_STREAM_HI, `RCM_PLLRCF_HI
    };

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic [NUM_FEAT-1:0] hit;
    logic [2:0]          win_offs [NUM_FEAT];
    logic [2:0]          offs_d;
    logic                any_hit;
    logic                wr_req;
    logic                rd_req;

    for (genvar i = 0; i < NUM_FEAT; i++) begin : g_win
        rcm_window #(
            .LO (WIN_LO[i]),
            .HI (WIN_HI[i])
        ) u_win (
            .addr   (mgmt_address),
            .hit    (hit[i]),
            .offset (win_offs[i])
        );
    end

    // Windows never overlap, so an OR of masked offsets is exact
    always_comb begin
        offs_d = 3'h0;
        for (int i = 0; i < NUM_FEAT; i++) begin
            offs_d = offs_d | (hit[i] ? win_offs[i] : 3'h0);
        end
    end

    // Any window hit lets the feature strobes through
    assign any_hit = |hit;

    // Trade-off: no error response, a dropped access simply vanishes
    // a read and write in one cycle is ambiguous, drop both
    assign wr_req = mgmt_write && !mgmt_read;
    assign rd_req = mgmt_read && !mgmt_write;

    // ------------------------------------------------------------------
    // Feature issue stage
    // ------------------------------------------------------------------
    logic [NUM_FEAT-1:0] sel_q;
    logic [2:0]          offs_q;
    logic                fwr_q;
    logic                frd_q;
    logic                rd_pend_q;
    logic [DATA_W-1:0]   wdata_q;

    // Unmapped reads still set rd_pend_q so every read gets its answer
    // one-hot select keeps each access in its own window
    // strobes leave on the clock edge after sampling
    // management reset holds the stage idle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sel_q     <= '0;
            offs_q    <= 3'h0;
            fwr_q     <= 1'b0;
            frd_q     <= 1'b0;
            rd_pend_q <= 1'b0;
        end else if (mgmt_reset) begin
            sel_q     <= '0;
            offs_q    <= 3'h0;
            fwr_q     <= 1'b0;
            frd_q     <= 1'b0;
            rd_pend_q <= 1'b0;
        end else begin
            // unmapped writes never reach a feature
            sel_q     <= (wr_req || rd_req) ? hit : '0;
            offs_q    <= (wr_req || rd_req) ? offs_d : 3'h0;
            fwr_q     <= wr_req && any_hit;
            frd_q     <= rd_req && any_hit;
            rd_pend_q <= rd_req;
        end
    end

    // Write data held with the strobe it belongs to
    // Not cleared after use, so a slow feature may sample it late
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wdata_q <= `RCM_RDATA_RST;
        end else if (mgmt_reset) begin
            wdata_q <= `RCM_RDATA_RST;
        end else if (wr_req) begin
            wdata_q <= mgmt_writedata;
        end
    end

    // ------------------------------------------------------------------
    // Read return stage
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] rsel_d;
    logic [DATA_W-1:0] rdata_q;
    logic              rvalid_q;

    // Masked OR mux, zero when no window was selected
    always_comb begin
        rsel_d = `RCM_UNMAPPED_RD;
        for (int i = 0; i < NUM_FEAT; i++) begin
            if (sel_q[i]) begin
                rsel_d = rsel_d | feat_readdata[i*DATA_W +: DATA_W];
            end
        end
    end

    // unmapped reads still answer, with zero
    // every read gets exactly one valid pulse
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q  <= `RCM_RDATA_RST;
            rvalid_q <= 1'b0;
        end else if (mgmt_reset) begin
            rdata_q  <= `RCM_RDATA_RST;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rd_pend_q;
            if (rd_pend_q) begin
                rdata_q <= rsel_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // Busy aggregation
    // ------------------------------------------------------------------
    logic busy_q;

    // One edge of lag buys a clean registered busy output
    // any feature at work makes the port busy
    // busy reads high while held in reset, like the calibrators
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busy_q <= 1'b1;
        end else if (mgmt_reset) begin
            busy_q <= 1'b1;
        end else begin
            busy_q <= |feat_busy;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Every output is a flop; no path from feat_readdata to the master
    assign mgmt_readdata      = rdata_q;
    assign mgmt_readdatavalid = rvalid_q;
    assign reconfig_busy      = busy_q;
    assign feat_sel           = sel_q;
    assign feat_offset        = offs_q;
    assign feat_write         = fwr_q;
    assign feat_read          = frd_q;
    assign feat_writedata     = wdata_q;

endmodule : rcm_port

// ---- rcm_feat_model.sv ----
// Far-side model of the seven register features
`timescale 1ns/1ps
module rcm_feat_model (
    input  wire logic         clock,
    input  wire logic         reset_n,
    input  wire logic [6:0]   feat_sel,
    input  wire logic [2:0]   feat_offset,
    input  wire logic         feat_write,
    output logic      [223:0] feat_readdata,
    output logic      [6:0]   feat_busy
);
    logic [2:0] busy_cnt_q;

    // Idle features show inverted data, so a wrong pick never matches
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            feat_readdata[i*32+:32] = {8'h5A, 13'h0000, 8'(i), feat_offset}
                                      ^ {32{!feat_sel[i]}};
        end
    end

    // A write starts a slow operation in the written feature
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busy_cnt_q <= 3'h0;
            feat_busy  <= 7'h00;
        end else if (feat_write) begin
            busy_cnt_q <= 3'h5;
            feat_busy  <= feat_sel;
        end else if (busy_cnt_q != 3'h0) begin
            busy_cnt_q <= busy_cnt_q - 3'h1;
        end else begin
            feat_busy <= 7'h00;
        end
    end
endmodule : rcm_feat_model

// ---- rcm_port_asserts.sv ----
// Checker bound to the register port
`timescale 1ns/1ps
module rcm_port_asserts (
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        mgmt_reset,
    input wire logic [6:0]  mgmt_address,
    input wire logic [31:0] mgmt_writedata,
    input wire logic        mgmt_write,
    input wire logic        mgmt_read,
    input wire logic        mgmt_readdatavalid,
    input wire logic        reconfig_busy,
    input wire logic [6:0]  feat_sel,
    input wire logic [2:0]  feat_offset,
    input wire logic        feat_write,
    input wire logic        feat_read,
    input wire logic [31:0] feat_writedata,
    input wire logic [6:0]  feat_busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Taken strobes; both together count as none
    wire       rd_t = mgmt_read && !mgmt_write && !mgmt_reset;
    wire       wr_t = mgmt_write && !mgmt_read && !mgmt_reset;
    wire [2:0] a_lo = mgmt_address[2:0];

    rd_latency_a: assert property (
        rd_t ##1 !mgmt_reset |=> mgmt_readdatavalid)
        else $error("read answer not two cycles later");
    busy_follow_a: assert property (
        $past(reset_n) && !$past(mgmt_reset) |->
        reconfig_busy == (|$past(feat_busy)))
        else $error("busy does not follow features");
    busy_rst_a: assert property (
        mgmt_reset |=> reconfig_busy && !mgmt_readdatavalid && !feat_sel)
        else $error("outputs not held in reset");
    analog_win_a: assert property (
        (rd_t || wr_t) && mgmt_address inside {[7'h08:7'h0C]}
        |=> feat_sel == 7'h01) else $error("analog window misrouted");
    pllrcf_win_a: assert property (
        (rd_t || wr_t) && mgmt_address inside {[7'h40:7'h44]}
        |=> feat_sel == 7'h40) else $error("pll window misrouted");
    byte_offset_a: assert property (
        feat_read || feat_write |-> feat_offset == $past(a_lo))
        else $error("byte offset wrong");
    wdata_pass_a: assert property (
        feat_write |-> feat_writedata == $past(mgmt_writedata))
        else $error("write data not passed");
    unmapped_drop_a: assert property (
        (rd_t || wr_t) && mgmt_address inside {[7'h00:7'h07],
        [7'h0D:7'h0F], [7'h15:7'h17], [7'h1D:7'h27], [7'h2D:7'h2F],
        [7'h35:7'h37], [7'h3D:7'h3F], [7'h45:7'h7F]}
        |=> !feat_sel && !feat_write && !feat_read)
        else $error("unmapped access reached a feature");
    both_drop_a: assert property (
        mgmt_read && mgmt_write |=> !feat_read && !feat_write)
        else $error("read with write not dropped");
endmodule : rcm_port_asserts

bind rcm_port rcm_port_asserts u_chk (.*);

// ---- reconfig_mgmt_register_port_tb.sv ----
// Self-checking bench for the register port
`timescale 1ns/1ps
module reconfig_mgmt_register_port_tb;
    import rcm_pkg::*;
    logic         clock, reset_n, mgmt_reset, mgmt_write, mgmt_read;
    logic         mgmt_readdatavalid, reconfig_busy, feat_write, feat_read;
    rcm_addr_t    mgmt_address;
    rcm_data_t    mgmt_writedata, mgmt_readdata, feat_writedata;
    logic [6:0]   feat_sel, feat_busy;
    logic [2:0]   feat_offset;
    logic [223:0] feat_readdata;
    int           failures, tests_run, cycles;

    rcm_port dut (.*);
    rcm_feat_model far_end (.*);

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Hang guard; the whole run needs about 260 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            complete_run();
        end
    end

    task automatic chk(input string w, input rcm_data_t e, input rcm_data_t g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", w, e, g);
        end
    endtask : chk

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    // One-cycle strobe from the master side
    task automatic strobe(input logic r, input logic w, input rcm_addr_t a,
                          input rcm_data_t d);
        @(negedge clock);
        mgmt_address   = a;
        mgmt_writedata = d;
        mgmt_read      = r;
        mgmt_write     = w;
        @(negedge clock);
        mgmt_read  = 1'b0;
        mgmt_write = 1'b0;
        chk("select", (f_of(a) < 0 || !(r ^ w)) ? 0 :
            32'h1 << f_of(a), 32'(feat_sel));
        if (f_of(a) >= 0 && (r ^ w))
            chk("offset", 32'(a[2:0]), 32'(feat_offset));
    endtask : strobe

    // Window index from the address, minus one when unmapped
    function automatic int f_of(input rcm_addr_t a);
        int m[16] = '{-1, 0, 1, 2, -1, 3, 4, 5, 6, -1, -1, -1, -1, -1, -1, -1};
        return (a[2:0] > 3'h4) ? -1 : m[a[6:3]];
    endfunction : f_of

    task automatic rd(input rcm_addr_t a);
        strobe(1'b1, 1'b0, a, 32'h0000_0000);
        chk("read strobe", 32'(f_of(a) >= 0), 32'(feat_read));
        @(negedge clock);
        chk("valid", 32'h0000_0001, 32'(mgmt_readdatavalid));
        chk("read data", (f_of(a) < 0) ? 0 :
            {8'h5A, 13'h0000, 8'(f_of(a)), a[2:0]}, mgmt_readdata);
    endtask : rd

    task automatic wr(input rcm_addr_t a, input rcm_data_t d);
        strobe(1'b0, 1'b1, a, d);
        chk("write strobe", 32'(f_of(a) >= 0), 32'(feat_write));
        chk("no answer", 32'h0, 32'(mgmt_readdatavalid));
        if (f_of(a) >= 0)
            chk("write data", d, feat_writedata);
    endtask : wr

    task automatic t_map();
        for (int a = 0; a < 128; a += 3) begin
            rd(7'(a));
            wr(7'(a), 32'hA5C3_0F00 ^ a);
        end
        $display("address map test done");
    endtask : t_map

    task automatic t_busy();
        repeat (12) @(negedge clock);
        wr(7'h32, 32'h0000_0001);
        repeat (2) @(negedge clock);
        chk("busy high", 32'h1, 32'(reconfig_busy));
        repeat (7) @(negedge clock);
        chk("busy low", 32'h0, 32'(reconfig_busy));
        $display("busy test done");
    endtask : t_busy

    task automatic t_both_and_reset();
        strobe(1'b1, 1'b1, 7'h0A, 32'h1234_5678);
        chk("collision", 32'h0, 32'({feat_read, feat_write}));
        rd(7'h3C);
        mgmt_reset = 1'b1;
        repeat (3) @(negedge clock);
        chk("reset busy", 32'h1, 32'(reconfig_busy));
        chk("reset data", 32'h0, mgmt_readdata);
        mgmt_reset = 1'b0;
        rd(7'h0C);
        $display("collision and reset test done");
    endtask : t_both_and_reset

    // Both resets asserted together, master idle
    initial begin
        reset_n        = 1'b0;
        mgmt_reset     = 1'b1;
        mgmt_read      = 1'b0;
        mgmt_write     = 1'b0;
        mgmt_address   = 7'h00;
        mgmt_writedata = 32'h0000_0000;
        repeat (12) @(negedge clock);
        reset_n    = 1'b1;
        mgmt_reset = 1'b0;
        t_map();
        t_busy();
        t_both_and_reset();
        complete_run();
    end
endmodule : reconfig_mgmt_register_port_tb
